// File: common/dchan_pins_cfg.svh
// Purpose : Offsets-free constants for the D-channel access and host pin block
// Assumes : Included by bare name from design files
// Notes   : Field positions, widths, reset values, state codes, a stage count and pattern constants only
`ifndef DCHAN_PINS_CFG_SVH
`define DCHAN_PINS_CFG_SVH

// ----------------------------------------------------------------------------
// Opening flag
// ----------------------------------------------------------------------------
`define CFG_FLAG_PATTERN   8'h7E
`define CFG_FLAG_LAST_IDX  3'h7
`define CFG_FLAG_FIRST_IDX 3'h0

// ----------------------------------------------------------------------------
// Synchronised pin bundle layout
// ----------------------------------------------------------------------------
`define CFG_PIN_W          5
`define CFG_PIN_CS_N       4
`define CFG_PIN_AS         3
`define CFG_PIN_DATA_STROBE_RD      2
`define CFG_PIN_RW_WR      1
`define CFG_PIN_REQ        0
`define CFG_PIN_RESET_VAL  5'h12

// ----------------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------------
`define CFG_STATE_W        2
`define CFG_CODE_00        2'h0
`define CFG_CODE_01        2'h1
`define CFG_CODE_10        2'h2
`define CFG_CODE_11        2'h3
`define CFG_SYNC_STAGES    2

`endif

// File: common/dchan_pins_pkg.sv
// Purpose : Types shared by the D-channel access and host pin block
// Assumes : Nothing beyond the language
// Notes   : Enumerations carry no explicit codes
`default_nettype none

package dchan_pins_pkg;

    typedef enum logic {
        BUS_RW_DS,
        BUS_RD_WR
    } bus_style_t;

    typedef enum logic [1:0] {
        DC_IDLE,
        DC_WAIT,
        DC_FLAG,
        DC_DATA
    } dchan_state_t;

    typedef enum logic [1:0] {
        NT_DEACT,
        NT_PEND_DEACT,
        NT_PEND_ACT,
        NT_ACT
    } nt_act_t;

    typedef enum logic [1:0] {
        TE_DEACT,
        TE_SYNC,
        TE_ACT_REQ,
        TE_ACT
    } te_act_t;

endpackage

`default_nettype wire

// File: core/pin_sync.sv
// Purpose : Two-flop synchroniser for a bundle of asynchronous pins
// Assumes : Synchronous active-high reset on the system clock
// Notes   : First stage feeds only the second stage
`default_nettype none

module pin_sync #(
    parameter int              WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_d,
    output logic      [WIDTH-1:0] o_q
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            meta_r <= RESET_VAL;
            o_q    <= RESET_VAL;
        end else begin
            meta_r <= i_d;
            o_q    <= meta_r;
        end
    end

endmodule

`default_nettype wire

// File: core/dchan_access_host_pins.sv
// Purpose : Mode-dependent control and status pin logic of an S/T transceiver
// Assumes : Pins arrive asynchronously; internal events share i_clk_sys
// Notes   : Open-drain pin driven low while its enable is high
//
// Operation
// - Processor access only with select low
// - Request sends flag now or when free
// - Request low sends continuous ones
// - Grant with first flag zero, terminal only
// - Grant released on lost contention, retry
// - Interrupt held until status register read
// - Select bit picks interrupt or new data
// - New data drives shared pin low
// - Address strobe rise samples bus style
// - Reset forces read/write plus strobe style
// - State outputs encode activation state, held at 00 while i_cmode is high
`include "dchan_pins_cfg.svh"
`default_nettype none

module dchan_access_host_pins (
    input  wire logic                     i_clk_sys,
    input  wire logic                     i_reset,
    // Mode straps
    input  wire logic                     i_cmode,
    input  wire logic                     i_te_mode,
    input  wire logic                     i_event_pin_select_bit,
    // Microprocessor port pins
    input  wire logic                     i_chip_sel_n,
    input  wire logic                     i_addr_strobe,
    input  wire logic                     i_data_strobe_rd,
    input  wire logic                     i_rw_wr,
    // Terminal D-channel pins and internal link side
    input  wire logic                     i_dchan_access_request,
    input  wire logic                     i_dchan_free,
    input  wire logic                     i_dchan_bit_tick,
    input  wire logic                     i_contention_lost,
    input  wire logic                     i_tx_packet_bit,
    // Internal event sources
    input  wire logic                     i_hdlc_irq_event,
    input  wire logic                     i_isr_read,
    input  wire logic                     i_new_rx_data,
    input  wire dchan_pins_pkg::nt_act_t  i_nt_state,
    input  wire dchan_pins_pkg::te_act_t  i_te_state,
    // Outputs
    output dchan_pins_pkg::bus_style_t    o_bus_style,
    output logic                          o_port_selected,
    output logic                          o_port_rd_pulse,
    output logic                          o_port_wr_pulse,
    output logic                          o_dchan_tx_bit,
    output logic                          o_dchan_access_grant,
    output logic                          o_event_pin_o,
    output logic                          o_event_pin_oe,
    output logic [`CFG_STATE_W-1:0]       o_link_state_code
);

    import dchan_pins_pkg::*;

    // ------------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------------
    logic [`CFG_PIN_W-1:0] pin_raw;
    logic [`CFG_PIN_W-1:0] pin_s;
    logic [`CFG_PIN_W-1:0] pin_q_r;

    assign pin_raw = {i_chip_sel_n, i_addr_strobe, i_data_strobe_rd, i_rw_wr,
                      i_dchan_access_request};

    pin_sync #(
        .WIDTH     (`CFG_PIN_W),
        .RESET_VAL (`CFG_PIN_RESET_VAL)
    ) u_pin_sync (
        .i_clk_sys (i_clk_sys),
        .i_reset   (i_reset),
        .i_d       (pin_raw),
        .o_q       (pin_s)
    );

    // Delayed copy for edge detection on already-synchronised pins
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            pin_q_r <= `CFG_PIN_RESET_VAL;
        end else begin
            pin_q_r <= pin_s;
        end
    end

    logic cs_n_s;
    logic as_rise;
    logic ds_s;
    logic ds_rise;
    logic ds_fall;
    logic rw_s;
    logic wr_fall;
    logic req_s;

    assign cs_n_s  = pin_s[`CFG_PIN_CS_N];
    assign as_rise = pin_s[`CFG_PIN_AS] & ~pin_q_r[`CFG_PIN_AS];
    assign ds_s    = pin_s[`CFG_PIN_DATA_STROBE_RD];
    assign ds_rise = ds_s & ~pin_q_r[`CFG_PIN_DATA_STROBE_RD];
    assign ds_fall = ~ds_s & pin_q_r[`CFG_PIN_DATA_STROBE_RD];
    assign rw_s    = pin_s[`CFG_PIN_RW_WR];
    assign wr_fall = ~rw_s & pin_q_r[`CFG_PIN_RW_WR];
    assign req_s   = pin_s[`CFG_PIN_REQ];

    // ------------------------------------------------------------------------
    // Bus style detection
    // ------------------------------------------------------------------------
    bus_style_t style_r;

    // Only an address strobe edge may change the style, so a strobe pin
    // never changes meaning in the middle of an access
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            style_r <= BUS_RW_DS;
        end else if (as_rise) begin
            style_r <= ds_s ? BUS_RD_WR : BUS_RW_DS;
        end
    end

    assign o_bus_style = style_r;

    // ------------------------------------------------------------------------
    // Processor access strobes
    // ------------------------------------------------------------------------
    logic selected;
    logic rd_nxt;
    logic wr_nxt;

    assign selected = i_cmode & ~cs_n_s;

    always_comb begin
        rd_nxt = 1'b0;
        wr_nxt = 1'b0;
        if (selected) begin
            if (style_r == BUS_RW_DS) begin
                rd_nxt = ds_rise & rw_s;
                wr_nxt = ds_rise & ~rw_s;
            end else begin
                rd_nxt = ds_fall;
                wr_nxt = wr_fall;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_port_selected <= 1'b0;
            o_port_rd_pulse <= 1'b0;
            o_port_wr_pulse <= 1'b0;
        end else begin
            o_port_selected <= selected;
            o_port_rd_pulse <= rd_nxt;
            o_port_wr_pulse <= wr_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // HDLC interrupt latch
    // ------------------------------------------------------------------------
    logic irq_pend_r;

    // A new event in the clearing cycle wins, so no interrupt is lost
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            irq_pend_r <= 1'b0;
        end else if (i_hdlc_irq_event) begin
            irq_pend_r <= 1'b1;
        end else if (i_isr_read) begin
            irq_pend_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // D-channel access handshake
    // ------------------------------------------------------------------------
    dchan_state_t dc_state_r;
    logic [2:0]   flag_idx_r;
    logic         grant_r;
    logic         tx_bit_r;
    logic         te_ctl;
    logic [7:0]   flag_pat;

    assign te_ctl   = ~i_cmode & i_te_mode;
    assign flag_pat = `CFG_FLAG_PATTERN;

    // Packet bits are taken once the eight flag bits, the first sent with the grant, are out;
    // the terminal is expected to keep up from the first bit slot after the flag
    always_ff @(posedge i_clk_sys) begin
        if (i_reset || !te_ctl) begin
            dc_state_r <= DC_IDLE;
            flag_idx_r <= `CFG_FLAG_FIRST_IDX;
            grant_r    <= 1'b0;
            tx_bit_r   <= 1'b1;
        end else begin
            case (dc_state_r)
                DC_IDLE: begin
                    grant_r  <= 1'b0;
                    tx_bit_r <= 1'b1;
                    if (req_s) begin
                        flag_idx_r <= `CFG_FLAG_FIRST_IDX;
                        dc_state_r <= i_dchan_free ? DC_FLAG : DC_WAIT;
                    end
                end
                DC_WAIT: begin
                    tx_bit_r <= 1'b1;
                    if (!req_s) begin
                        dc_state_r <= DC_IDLE;
                    end else if (i_dchan_free) begin
                        flag_idx_r <= `CFG_FLAG_FIRST_IDX;
                        dc_state_r <= DC_FLAG;
                    end
                end
                DC_FLAG: begin
                    if (!req_s) begin
                        grant_r    <= 1'b0;
                        tx_bit_r   <= 1'b1;
                        dc_state_r <= DC_IDLE;
                    end else if (i_contention_lost) begin
                        grant_r    <= 1'b0;
                        tx_bit_r   <= 1'b1;
                        dc_state_r <= DC_WAIT;
                    end else if (i_dchan_bit_tick) begin
                        tx_bit_r <= flag_pat[3'h7 - flag_idx_r];
                        if (flag_idx_r == `CFG_FLAG_FIRST_IDX) begin
                            grant_r <= 1'b1;
                        end
                        if (flag_idx_r == `CFG_FLAG_LAST_IDX) begin
                            dc_state_r <= DC_DATA;
                        end
                        flag_idx_r <= flag_idx_r + 3'h1;
                    end
                end
                DC_DATA: begin
                    if (!req_s) begin
                        grant_r    <= 1'b0;
                        tx_bit_r   <= 1'b1;
                        dc_state_r <= DC_IDLE;
                    end else if (i_contention_lost) begin
                        grant_r    <= 1'b0;
                        tx_bit_r   <= 1'b1;
                        dc_state_r <= DC_WAIT;
                    end else if (i_dchan_bit_tick) begin
                        tx_bit_r <= i_tx_packet_bit;
                    end
                end
                default: begin
                    grant_r    <= 1'b0;
                    tx_bit_r   <= 1'b1;
                    dc_state_r <= DC_IDLE;
                end
            endcase
        end
    end

    assign o_dchan_tx_bit       = tx_bit_r;
    assign o_dchan_access_grant = grant_r;

    // ------------------------------------------------------------------------
    // Shared open-drain event pin
    // ------------------------------------------------------------------------
    logic event_oe_nxt;

    always_comb begin
        event_oe_nxt = 1'b0;
        if (i_cmode) begin
            if (i_event_pin_select_bit) begin
                event_oe_nxt = i_new_rx_data;
            end else begin
                event_oe_nxt = irq_pend_r;
            end
        end else if (i_te_mode) begin
            event_oe_nxt = grant_r;
        end
    end

    // Output level is held low; only the enable ever moves
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_event_pin_o  <= 1'b0;
            o_event_pin_oe <= 1'b0;
        end else begin
            o_event_pin_o  <= 1'b0;
            o_event_pin_oe <= event_oe_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Activation state outputs
    // ------------------------------------------------------------------------
    logic [`CFG_STATE_W-1:0] state_code_nxt;

    always_comb begin
        state_code_nxt = `CFG_CODE_00;
        if (!i_cmode) begin
            if (i_te_mode) begin
                case (i_te_state)
                    TE_DEACT:   state_code_nxt = `CFG_CODE_00;
                    TE_SYNC:    state_code_nxt = `CFG_CODE_01;
                    TE_ACT_REQ: state_code_nxt = `CFG_CODE_10;
                    TE_ACT:     state_code_nxt = `CFG_CODE_11;
                    default:    state_code_nxt = `CFG_CODE_00;
                endcase
            end else begin
                case (i_nt_state)
                    NT_DEACT:      state_code_nxt = `CFG_CODE_00;
                    NT_PEND_DEACT: state_code_nxt = `CFG_CODE_01;
                    NT_PEND_ACT:   state_code_nxt = `CFG_CODE_10;
                    NT_ACT:        state_code_nxt = `CFG_CODE_11;
                    default:       state_code_nxt = `CFG_CODE_00;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_link_state_code <= `CFG_CODE_00;
        end else begin
            o_link_state_code <= state_code_nxt;
        end
    end

endmodule

`default_nettype wire

// File: tb/dchan_pins_chk.sv
// Purpose: Port checks for the D-channel host pin block
// Assumes: One clock, synchronous active-high reset
// Notes  : Bound onto the top module after endmodule
`default_nettype none
module dchan_pins_chk (
    input wire logic                       i_clk_sys,
    input wire logic                       i_reset,
    input wire logic                       i_cmode,
    input wire logic                       i_event_pin_select_bit,
    input wire logic                       i_addr_strobe,
    input wire logic                       i_dchan_access_request,
    input wire logic                       i_dchan_bit_tick,
    input wire logic                       i_contention_lost,
    input wire logic                       i_hdlc_irq_event,
    input wire logic                       i_isr_read,
    input wire logic                       i_new_rx_data,
    input wire dchan_pins_pkg::bus_style_t o_bus_style,
    input wire logic                       o_port_selected,
    input wire logic                       o_port_rd_pulse,
    input wire logic                       o_port_wr_pulse,
    input wire logic                       o_dchan_tx_bit,
    input wire logic                       o_dchan_access_grant,
    input wire logic                       o_event_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    import dchan_pins_pkg::*;
    logic       irq_mode;
    logic [2:0] as_age_r;
    assign irq_mode = i_cmode && !i_event_pin_select_bit;
    // Saturating age, so an old strobe never excuses a style change
    always_ff @(posedge i_clk_sys) begin
        if (i_reset)
            as_age_r <= 3'h7;
        else if ($rose(i_addr_strobe))
            as_age_r <= 3'h0;
        else if (as_age_r != 3'h7)
            as_age_r <= as_age_r + 3'h1;
    end
    // ----
    // Properties
    // ----
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    sequence s_irq_set;
        i_hdlc_irq_event && irq_mode ##1 irq_mode;
    endsequence
    sequence s_irq_clr;
        i_isr_read && !i_hdlc_irq_event && irq_mode ##1 irq_mode;
    endsequence
    property p_style_hold;
        $changed(o_bus_style) |-> as_age_r != 3'h7;
    endproperty
    a_style_hold: assert property (p_style_hold) else $error("style moved");
    property p_sel;
        o_port_rd_pulse || o_port_wr_pulse |-> o_port_selected && $past(i_cmode);
    endproperty
    a_sel: assert property (p_sel) else $error("access unselected");
    property p_irq_set;
        s_irq_set |=> o_event_pin_oe;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("irq not shown");
    property p_irq_hold;
        o_event_pin_oe && irq_mode && $past(irq_mode) && !$past(i_isr_read) |=> o_event_pin_oe;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
    property p_irq_clr;
        s_irq_clr |=> !o_event_pin_oe;
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("irq not cleared");
    property p_ndata;
        i_cmode && i_event_pin_select_bit |=> o_event_pin_oe == $past(i_new_rx_data);
    endproperty
    a_ndata: assert property (p_ndata) else $error("new data pin wrong");
    property p_ones;
        (!i_dchan_access_request) [*5] |-> o_dchan_tx_bit && !o_dchan_access_grant;
    endproperty
    a_ones: assert property (p_ones) else $error("ones not sent");
    property p_grant_zero;
        $rose(o_dchan_access_grant) |-> !o_dchan_tx_bit && $past(i_dchan_bit_tick);
    endproperty
    a_grant_zero: assert property (p_grant_zero) else $error("grant early");
    property p_lost;
        o_dchan_access_grant && i_contention_lost |=> !o_dchan_access_grant;
    endproperty
    a_lost: assert property (p_lost) else $error("grant kept");
endmodule
bind dchan_access_host_pins dchan_pins_chk u_chk (.*);
`default_nettype wire

// File: tb/term_model.sv
// Purpose: Terminal logic feeding D-channel packets
// Assumes: Same clock as the block
// Notes  : Bit toggles while ungranted, so stale use shows
`default_nettype none
module term_model (
    input  wire logic i_clk_sys,
    input  wire logic i_reset,
    input  wire logic i_send,
    input  wire logic i_grant,
    input  wire logic i_tick,
    output var logic  o_req,
    output logic      o_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] pkt_r  = 8'hA5;
    logic       junk_r = 1'b1;
    assign o_bit = i_grant ? pkt_r[7] : junk_r;
    always @(posedge i_clk_sys) begin
        o_req  <= i_send && !i_reset;
        junk_r <= !junk_r;
        if (!i_grant)
            pkt_r <= 8'hA5;
        else if (i_tick)
            pkt_r <= {pkt_r[6:0], pkt_r[7]};
    end
endmodule
`default_nettype wire

// File: tb/tb.sv
// Purpose: Self-checking bench of the D-channel host pin block
// Assumes: 25 MHz clock, synchronous active-high reset
// Notes  : Inputs move 1 ns after the rising edge
`include "dchan_pins_cfg.svh"
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dchan_pins_pkg::*;
    logic       i_clk_sys, i_reset, i_cmode, i_te_mode, i_event_pin_select_bit;
    logic       i_chip_sel_n, i_addr_strobe, i_data_strobe_rd, i_rw_wr;
    logic       i_dchan_access_request, i_dchan_free, i_dchan_bit_tick;
    logic       i_contention_lost, i_tx_packet_bit, i_hdlc_irq_event, i_isr_read;
    logic       i_new_rx_data, o_port_selected, o_port_rd_pulse, o_port_wr_pulse;
    logic       o_dchan_tx_bit, o_dchan_access_grant, o_event_pin_o, o_event_pin_oe;
    logic [1:0] o_link_state_code;
    logic [7:0] flag_pat = `CFG_FLAG_PATTERN;
    nt_act_t    i_nt_state;
    te_act_t    i_te_state;
    bus_style_t o_bus_style, style;
    logic       send;
    logic       q[$];
    int         error_cnt = 0, n_compared = 0, nrd, nwr;

    dchan_access_host_pins uut (.*);
    term_model u_term (.i_clk_sys, .i_reset, .i_send(send), .i_grant(o_dchan_access_grant),
        .i_tick(i_dchan_bit_tick), .o_req(i_dchan_access_request), .o_bit(i_tx_packet_bit));

    initial begin
        i_clk_sys = 1'b0;
        forever #20 i_clk_sys = ~i_clk_sys;
    end
    // ----
    // Tasks
    // ----
    task automatic step(input int n = 1);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic strobe(input logic ds);
        i_data_strobe_rd = ds;
        step(4);
        i_addr_strobe = 1'b1;
        step(4);
        i_addr_strobe = 1'b0;
        i_data_strobe_rd = !ds;
        step(6);
        style = ds ? BUS_RD_WR : BUS_RW_DS;
        `CHK(o_bus_style, style)
    endtask
    task automatic acc(input logic cs, input logic rd);
        nrd = 0;
        nwr = 0;
        i_chip_sel_n = cs;
        i_data_strobe_rd = (style == BUS_RD_WR);
        i_rw_wr = (style == BUS_RD_WR) || rd;
        step(4);
        `CHK(o_port_selected, i_cmode && !cs)
        if (style == BUS_RD_WR && rd)
            i_data_strobe_rd = 1'b0;
        else if (style == BUS_RD_WR)
            i_rw_wr = 1'b0;
        else
            i_data_strobe_rd = 1'b1;
        repeat (12) begin
            step();
            nrd += (o_port_rd_pulse !== 1'b0);
            nwr += (o_port_wr_pulse !== 1'b0);
        end
        `CHK(nrd, int'(i_cmode && !cs && rd))
        `CHK(nwr, int'(i_cmode && !cs && !rd))
    endtask
    // Expected line bit: queued flag or ones, else the packet bit offered now
    task automatic tick(input logic gr);
        logic e;
        e = (q.size() > 0) ? q.pop_front() : i_tx_packet_bit;
        i_dchan_bit_tick = 1'b1;
        step();
        i_dchan_bit_tick = 1'b0;
        `CHK(o_dchan_tx_bit, e)
        `CHK(o_dchan_access_grant, gr)
        step(2);
    endtask
    // ----
    // Tests
    // ----
    initial begin
        i_reset = 1'b1;
        {i_cmode, i_te_mode, i_event_pin_select_bit, i_addr_strobe, i_data_strobe_rd,
         i_dchan_free, i_dchan_bit_tick, i_contention_lost, i_hdlc_irq_event,
         i_isr_read, i_new_rx_data, send} = '0;
        {i_chip_sel_n, i_rw_wr} = 2'h3;
        i_nt_state = NT_DEACT;
        i_te_state = TE_DEACT;
        style = BUS_RW_DS;
        void'($urandom(67072));
        step(20);
        i_reset = 1'b0;
        step();
        `CHK(o_bus_style, BUS_RW_DS)
        `CHK(o_dchan_tx_bit, 1'b1)
        $display("test reset done");
        for (int s = 0; s < 2; s++) begin
            i_cmode = 1'b1;
            strobe(s[0]);
            for (int k = 0; k < 8; k++) begin
                i_cmode = k[2];
                acc(k[1], k[0]);
            end
        end
        i_reset = 1'b1;
        step(4);
        i_reset = 1'b0;
        step();
        `CHK(o_bus_style, BUS_RW_DS)
        style = BUS_RW_DS;
        $display("test port done");
        i_new_rx_data = 1'b1;
        step(3);
        `CHK(o_event_pin_oe, 1'b0)
        `CHK(o_link_state_code, 2'h0)
        i_hdlc_irq_event = 1'b1;
        step();
        i_hdlc_irq_event = 1'b0;
        step(2 + $urandom_range(5));
        `CHK(o_event_pin_oe, 1'b1)
        `CHK(o_event_pin_o, 1'b0)
        // Event in the clearing cycle keeps the pin low
        {i_hdlc_irq_event, i_isr_read} = 2'h3;
        step();
        {i_hdlc_irq_event, i_isr_read} = 2'h0;
        step(2);
        `CHK(o_event_pin_oe, 1'b1)
        i_isr_read = 1'b1;
        step();
        i_isr_read = 1'b0;
        step(2);
        `CHK(o_event_pin_oe, 1'b0)
        i_event_pin_select_bit = 1'b1;
        repeat (16) begin
            i_new_rx_data = 1'($urandom_range(1));
            step();
            `CHK(o_event_pin_oe, i_new_rx_data)
        end
        $display("test event pin done");
        i_cmode = 1'b0;
        for (int k = 0; k < 8; k++) begin
            i_te_mode = k[2];
            i_nt_state = nt_act_t'(k[1:0]);
            i_te_state = te_act_t'(~k[1:0]);
            step();
            `CHK(o_link_state_code, k[2] ? ~k[1:0] : k[1:0])
        end
        $display("test state done");
        // Network mode ignores the request and leaves the pin alone
        i_te_mode = 1'b0;
        i_dchan_free = 1'b1;
        send = 1'b1;
        step(6);
        q.push_back(1'b1);
        tick(1'b0);
        `CHK(o_event_pin_oe, 1'b0)
        i_te_mode = 1'b1;
        i_dchan_free = 1'b0;
        step(6);
        repeat (3) begin
            q.push_back(1'b1);
            tick(1'b0);
        end
        i_dchan_free = 1'b1;
        step(3);
        for (int r = 0; r < 2; r++) begin
            for (int b = 7; b >= 0; b--)
                q.push_back(flag_pat[b]);
            // Second round loses the channel while the flag is going out
            repeat (r ? 4 : 12) tick(1'b1);
            `CHK(o_event_pin_oe, 1'b1)
            i_contention_lost = 1'b1;
            step();
            i_contention_lost = 1'b0;
            q.delete();
            `CHK(o_dchan_access_grant, 1'b0)
            `CHK(o_dchan_tx_bit, 1'b1)
            step(3);
        end
        send = 1'b0;
        step(6);
        q.push_back(1'b1);
        tick(1'b0);
        $display("test dchannel done");
        summarize();
    end
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        error_cnt++;
        summarize();
    end
endmodule
`default_nettype wire
